// ===== hdl/rel_offset_pkg.sv
// What this block does
// - Signed per-function offset, zero default, range-checked
// - Enabled subtraction: reading equals raw minus offset
// - Concurrent function offsets current only, voltage untouched
// - Per-function subtraction enable, default disabled
// - Capture command stores one new measurement
// - Capture measurement bypasses averaging filter
// - Capture error keeps previous offset value
// - Capture accepted only for active function
// - Overflow or trigger wait rejects with -200
// - Offset read returns latest captured or written
// - Resolution codes 4,5,6; default 6
// - Code 4 presets fast, filter on
// - Code 5 presets medium, delay on
// - Code 6 presets slow, autozero on
// - Delay 0..99 s, 10 us steps, default 1 ms
// - Wait source delay after output on before measuring
// - One delay shared by voltage and current sourcing
// - Negative delay write rejected with -222
// - Delay enable, default on, gates the wait
package rel_offset_pkg;
  // Readings in micro-units (uA or uV), two's complement
  localparam int unsigned VAL_W = 32;
  localparam int signed CURR_LIMIT_U = 6100000;
  localparam int signed VOLT_LIMIT_U = 20000000;

  typedef enum logic [1:0] {
    FN_CONC = 2'b00,
    FN_CURR = 2'b01,
    FN_VOLT = 2'b10
  } func_t;

  localparam int unsigned NUM_FN = 3;

  // Source delay in 10 us ticks
  localparam int unsigned DLY_W = 24;
  localparam int unsigned DLY_STEP_NS = 10000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_CYCLES = DLY_STEP_NS / CLK_PERIOD_NS;
  localparam int signed DLY_MAX_TICKS = 9900000;
  localparam logic [DLY_W-1:0] DLY_RESET = 24'h000064;
  localparam logic [DLY_W-1:0] DLY_1MS = 24'h000064;
  localparam logic [DLY_W-1:0] DLY_ZERO = 24'h000000;

  // Resolution codes
  localparam logic [2:0] RES_4 = 3'h4;
  localparam logic [2:0] RES_5 = 3'h5;
  localparam logic [2:0] RES_6 = 3'h6;
  localparam logic [2:0] RES_RESET = 3'h6;

  // Integration in units of 0.01 line cycle
  localparam logic [15:0] LCI_RES4 = 16'h0001;
  localparam logic [15:0] LCI_RES5 = 16'h000a;
  localparam logic [15:0] LCI_RES6 = 16'h0064;
  localparam logic [7:0] FILT_COUNT = 8'h0a;
  // Window in units of 0.01 percent
  localparam logic [7:0] FILT_WINDOW = 8'h01;

  localparam logic signed [15:0] ERR_EXEC = 16'shff38;
  localparam logic signed [15:0] ERR_RANGE = 16'shff22;
  localparam logic signed [15:0] ERR_NONE = 16'sh0000;

  typedef struct packed {
    logic [15:0] line_cycle_integration;
    logic        autozero;
    logic [7:0]  filt_count;
    logic [7:0]  filt_window;
    logic        filt_en;
  } meas_cfg_t;

  localparam meas_cfg_t CFG_RESET = '{LCI_RES6, 1'b1, FILT_COUNT, FILT_WINDOW, 1'b0};

  typedef struct packed {
    logic                    valid;
    logic                    overflow;
    logic signed [VAL_W-1:0] volt;
    logic signed [VAL_W-1:0] curr;
  } raw_meas_t;
endpackage : rel_offset_pkg

// ===== hdl/err_latch.sv
`timescale 1ns/10ps
module err_latch (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Error events
  input  wire logic                raise,
  input  wire logic signed [15:0]  code,
  // Host read
  input  wire logic                rd,
  output logic signed [15:0]       err_code,
  output logic                     err_pending
);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      err_code    <= rel_offset_pkg::ERR_NONE;
      err_pending <= 1'b0;
    end else if (raise) begin
      err_code    <= code;
      err_pending <= 1'b1;
    end else if (rd) begin
      err_pending <= 1'b0;
    end
  end
endmodule : err_latch

// ===== hdl/settle_timer.sv
`timescale 1ns/10ps
module settle_timer #(
  parameter int unsigned TICK_CYCLES = rel_offset_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                               clk_sys,
  input  wire logic                               rst,
  // Control
  input  wire logic                               start,
  input  wire logic                               abort,
  input  wire logic [rel_offset_pkg::DLY_W-1:0]   ticks,
  output logic                                    done
);
  logic [15:0]                       pre_ff;
  logic [rel_offset_pkg::DLY_W-1:0]  cnt_ff;
  logic                              run_ff;
  wire                               tick = (pre_ff == 16'(TICK_CYCLES - 1));

  always_ff @(posedge clk_sys) begin
    if (rst || abort) begin
      pre_ff <= 16'h0000;
      cnt_ff <= '0;
      run_ff <= 1'b0;
      done   <= 1'b0;
    end else if (start) begin
      pre_ff <= 16'h0000;
      cnt_ff <= ticks;
      run_ff <= (ticks != '0);
      done   <= (ticks == '0);
    end else if (run_ff) begin
      pre_ff <= tick ? 16'h0000 : pre_ff + 16'h0001;
      if (tick) begin
        cnt_ff <= cnt_ff - 1'b1;
        if (cnt_ff == 1) begin
          run_ff <= 1'b0;
          done   <= 1'b1;
        end
      end
    end
  end
endmodule : settle_timer

// ===== hdl/rel_offset_ctrl.sv
`timescale 1ns/10ps
module rel_offset_ctrl (
  // Clock and reset
  input  wire logic                                    clk_sys,
  input  wire logic                                    rst,
  // Active function and raw measurements
  input  wire rel_offset_pkg::func_t                   active_fn,
  input  wire rel_offset_pkg::raw_meas_t               raw,
  input  wire logic                                    trig_wait,
  // Offset write
  input  wire logic                                    ofs_wr,
  input  wire rel_offset_pkg::func_t                   ofs_wr_fn,
  input  wire logic signed [rel_offset_pkg::VAL_W-1:0] ofs_wr_val,
  // Offset enable write
  input  wire logic                                    ofs_en_wr,
  input  wire rel_offset_pkg::func_t                   ofs_en_fn,
  input  wire logic                                    ofs_en_val,
  // Offset capture command
  input  wire logic                                    cap_cmd,
  input  wire rel_offset_pkg::func_t                   cap_fn,
  // Resolution select
  input  wire logic                                    res_wr,
  input  wire logic [2:0]                              res_val,
  // Source delay
  input  wire logic                                    dly_wr,
  input  wire logic signed [31:0]                      dly_val,
  input  wire logic                                    dly_en_wr,
  input  wire logic                                    dly_en_val,
  input  wire logic                                    output_on,
  // Error readback
  input  wire logic                                    err_rd,
  // Offset readback
  input  wire rel_offset_pkg::func_t                   ofs_rd_fn,
  output logic signed [rel_offset_pkg::VAL_W-1:0]      ofs_rd_val,
  // Processed readings
  output logic                                         rd_valid,
  output logic signed [rel_offset_pkg::VAL_W-1:0]      rd_volt,
  output logic signed [rel_offset_pkg::VAL_W-1:0]      rd_curr,
  // Measurement settings
  output rel_offset_pkg::meas_cfg_t                    meas_cfg,
  output logic                                         filt_bypass,
  output logic [2:0]                                   res_code,
  output logic [rel_offset_pkg::DLY_W-1:0]             dly_ticks,
  output logic                                         dly_en,
  output logic                                         meas_allowed,
  // Error status
  output logic signed [15:0]                           err_code,
  output logic                                         err_pending
);
  localparam int unsigned VW = rel_offset_pkg::VAL_W;

  logic signed [VW-1:0]       ofs_ff [rel_offset_pkg::NUM_FN];
  logic                       ofs_en_ff [rel_offset_pkg::NUM_FN];
  logic                       cap_busy_ff;
  rel_offset_pkg::func_t      cap_fn_ff;
  logic                       on_d_ff;
  logic                       settling_ff;

  // Range check for writes
  wire signed [VW-1:0] lim = (ofs_wr_fn == rel_offset_pkg::FN_VOLT) ?
                             VW'(rel_offset_pkg::VOLT_LIMIT_U) : VW'(rel_offset_pkg::CURR_LIMIT_U);
  wire ofs_in_range = (ofs_wr_val <= lim) && (ofs_wr_val >= -lim);
  wire ofs_wr_ok    = ofs_wr && ofs_in_range && (ofs_wr_fn != 2'b11);

  // Capture acceptance
  wire cap_fn_ok  = cap_cmd && (cap_fn == active_fn) && (cap_fn != 2'b11);
  wire cap_reject = cap_fn_ok && trig_wait;
  wire cap_start  = cap_fn_ok && !trig_wait && !cap_busy_ff;
  wire cap_sample = cap_busy_ff && raw.valid;
  wire cap_ovf    = cap_sample && raw.overflow;
  wire cap_good   = cap_sample && !raw.overflow;
  wire signed [VW-1:0] cap_value = (cap_fn_ff == rel_offset_pkg::FN_VOLT) ? raw.volt : raw.curr;

  // Source delay write checks
  wire dly_neg     = dly_wr && dly_val[31];
  wire dly_too_big = dly_wr && !dly_val[31] && (dly_val > rel_offset_pkg::DLY_MAX_TICKS);
  wire dly_ok      = dly_wr && !dly_neg && !dly_too_big;

  wire res_ok = res_wr && (res_val == rel_offset_pkg::RES_4 || res_val == rel_offset_pkg::RES_5 ||
                           res_val == rel_offset_pkg::RES_6);

  // Error selection
  wire err_raise = cap_reject || cap_ovf || dly_neg || dly_too_big ||
                   (cap_cmd && !cap_fn_ok);
  wire signed [15:0] err_sel = (dly_neg || dly_too_big) ? rel_offset_pkg::ERR_RANGE
                                                        : rel_offset_pkg::ERR_EXEC;

  // Offset subtraction on the live function
  wire [1:0] afn = active_fn;
  wire signed [VW-1:0] act_ofs = (afn == 2'b11) ? '0 : ofs_ff[afn];
  wire act_en = (afn != 2'b11) && ofs_en_ff[afn];
  wire signed [VW-1:0] sub_curr = raw.curr - act_ofs;
  wire signed [VW-1:0] sub_volt = raw.volt - act_ofs;
  wire apply_curr = act_en && (active_fn != rel_offset_pkg::FN_VOLT);
  wire apply_volt = act_en && (active_fn == rel_offset_pkg::FN_VOLT);
  wire settle_done;

  genvar g;
  generate
    for (g = 0; g < rel_offset_pkg::NUM_FN; g++) begin : g_fn
      wire wr_hit  = ofs_wr_ok && (ofs_wr_fn == 2'(g));
      wire cap_hit = cap_good && (cap_fn_ff == 2'(g));
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          ofs_ff[g]    <= '0;
          ofs_en_ff[g] <= 1'b0;
        end else begin
          if (cap_hit) begin
            ofs_ff[g] <= cap_value;
          end else if (wr_hit) begin
            ofs_ff[g] <= ofs_wr_val;
          end
          if (ofs_en_wr && ofs_en_fn == 2'(g)) begin
            ofs_en_ff[g] <= ofs_en_val;
          end
        end
      end
    end
  endgenerate

  // Capture sequencer; an overflowed sample leaves the offset alone
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cap_busy_ff <= 1'b0;
      cap_fn_ff   <= rel_offset_pkg::FN_CONC;
      filt_bypass <= 1'b0;
    end else if (cap_start) begin
      cap_busy_ff <= 1'b1;
      cap_fn_ff   <= cap_fn;
      filt_bypass <= 1'b1;
    end else if (cap_sample) begin
      cap_busy_ff <= 1'b0;
      filt_bypass <= 1'b0;
    end
  end

  // Resolution presets
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      res_code  <= rel_offset_pkg::RES_RESET;
      meas_cfg  <= rel_offset_pkg::CFG_RESET;
      dly_ticks <= rel_offset_pkg::DLY_RESET;
      dly_en    <= 1'b1;
    end else begin
      if (res_ok) begin
        res_code <= res_val;
        case (res_val)
          rel_offset_pkg::RES_4: begin
            meas_cfg  <= '{rel_offset_pkg::LCI_RES4, 1'b0, rel_offset_pkg::FILT_COUNT,
                           rel_offset_pkg::FILT_WINDOW, 1'b1};
            dly_ticks <= rel_offset_pkg::DLY_ZERO;
            dly_en    <= 1'b0;
          end
          rel_offset_pkg::RES_5: begin
            meas_cfg  <= '{rel_offset_pkg::LCI_RES5, 1'b0, rel_offset_pkg::FILT_COUNT,
                           rel_offset_pkg::FILT_WINDOW, 1'b0};
            dly_ticks <= rel_offset_pkg::DLY_1MS;
            dly_en    <= 1'b1;
          end
          default: begin
            meas_cfg  <= '{rel_offset_pkg::LCI_RES6, 1'b1, rel_offset_pkg::FILT_COUNT,
                           rel_offset_pkg::FILT_WINDOW, 1'b0};
            dly_ticks <= rel_offset_pkg::DLY_1MS;
            dly_en    <= 1'b1;
          end
        endcase
      end else begin
        if (dly_ok) begin
          dly_ticks <= dly_val[rel_offset_pkg::DLY_W-1:0];
        end
        if (dly_en_wr) begin
          dly_en <= dly_en_val;
        end
      end
    end
  end

  // Settling wait after output turn-on
  wire turn_on  = output_on && !on_d_ff;
  wire wait_req = turn_on && dly_en && (dly_ticks != '0);

  settle_timer u_settle (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (wait_req),
    .abort   (!output_on),
    .ticks   (dly_ticks),
    .done    (settle_done)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      on_d_ff      <= 1'b0;
      settling_ff  <= 1'b0;
      meas_allowed <= 1'b0;
    end else begin
      on_d_ff <= output_on;
      if (!output_on) begin
        settling_ff <= 1'b0;
      end else if (wait_req) begin
        settling_ff <= 1'b1;
      end else if (settle_done) begin
        settling_ff <= 1'b0;
      end
      meas_allowed <= output_on && !wait_req && !(settling_ff && !settle_done);
    end
  end

  // Reading and offset readback registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_valid   <= 1'b0;
      rd_volt    <= '0;
      rd_curr    <= '0;
      ofs_rd_val <= '0;
    end else begin
      rd_valid   <= raw.valid && !cap_busy_ff;
      rd_volt    <= apply_volt ? sub_volt : raw.volt;
      rd_curr    <= apply_curr ? sub_curr : raw.curr;
      ofs_rd_val <= (ofs_rd_fn == 2'b11) ? '0 : ofs_ff[ofs_rd_fn];
    end
  end

  err_latch u_err (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .raise       (err_raise),
    .code        (err_sel),
    .rd          (err_rd),
    .err_code    (err_code),
    .err_pending (err_pending)
  );
endmodule : rel_offset_ctrl

// ===== verification/relative_offset_and_source_delay_monitor.sv
`timescale 1ns/10ps
module relative_offset_and_source_delay_monitor (
  // Clock and reset
  input wire logic                      clk_sys,
  input wire logic                      rst,
  // Watched ports
  input wire rel_offset_pkg::func_t     active_fn,
  input wire rel_offset_pkg::func_t     cap_fn,
  input wire rel_offset_pkg::raw_meas_t raw,
  input wire logic                      trig_wait,
  input wire logic                      cap_cmd,
  input wire logic                      res_wr,
  input wire logic [2:0]                res_val,
  input wire logic                      dly_wr,
  input wire logic signed [31:0]        dly_val,
  input wire logic                      output_on,
  input wire logic                      err_rd,
  input wire logic                      rd_valid,
  input wire logic signed [31:0]        rd_volt,
  input wire rel_offset_pkg::meas_cfg_t meas_cfg,
  input wire logic                      filt_bypass,
  input wire logic [23:0]               dly_ticks,
  input wire logic                      dly_en,
  input wire logic                      meas_allowed,
  input wire logic signed [15:0]        err_code,
  input wire logic                      err_pending
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire smp = raw.valid && !filt_bypass && !cap_cmd;
  property p_rd; smp |=> rd_valid; endproperty
  a_rd: assert property (p_rd) else $error("reading not reported");
  property p_conc; smp && active_fn == rel_offset_pkg::FN_CONC |=> rd_volt == $past(raw.volt);
  endproperty
  a_conc: assert property (p_conc) else $error("voltage altered");
  property p_cap;
    cap_cmd && cap_fn == active_fn && !trig_wait && !filt_bypass |=> filt_bypass;
  endproperty
  a_cap: assert property (p_cap) else $error("capture not bypassing");
  property p_fn; cap_cmd && cap_fn != active_fn && !filt_bypass
    |=> err_pending && err_code == rel_offset_pkg::ERR_EXEC; endproperty
  a_fn: assert property (p_fn) else $error("wrong function accepted");
  property p_trg; cap_cmd && trig_wait && !filt_bypass
    |=> err_pending && err_code == rel_offset_pkg::ERR_EXEC; endproperty
  a_trg: assert property (p_trg) else $error("capture while waiting");
  property p_neg; dly_wr && dly_val < 0 && !res_wr
    |=> err_code == rel_offset_pkg::ERR_RANGE && dly_ticks == $past(dly_ticks); endproperty
  a_neg: assert property (p_neg) else $error("negative delay taken");
  property p_r4; res_wr && res_val == rel_offset_pkg::RES_4
    |=> meas_cfg.filt_en && !meas_cfg.autozero && dly_ticks == 24'h000000 && !dly_en;
  endproperty
  a_r4: assert property (p_r4) else $error("code 4 preset wrong");
  property p_r6; res_wr && res_val == rel_offset_pkg::RES_6
    |=> meas_cfg.autozero && !meas_cfg.filt_en && dly_ticks == rel_offset_pkg::DLY_1MS;
  endproperty
  a_r6: assert property (p_r6) else $error("code 6 preset wrong");
  property p_set; $rose(output_on) && dly_en && dly_ticks != 0 |=> !meas_allowed [*8];
  endproperty
  a_set: assert property (p_set) else $error("measured before settling");
  property p_off; !output_on |=> !meas_allowed; endproperty
  a_off: assert property (p_off) else $error("measuring with output off");
  property p_pend; err_pending && !err_rd |=> err_pending; endproperty
  a_pend: assert property (p_pend) else $error("pending lost");
endmodule : relative_offset_and_source_delay_monitor
bind rel_offset_ctrl relative_offset_and_source_delay_monitor u_mon (
  .clk_sys(clk_sys), .rst(rst), .active_fn(active_fn), .cap_fn(cap_fn), .raw(raw),
  .trig_wait(trig_wait), .cap_cmd(cap_cmd), .res_wr(res_wr), .res_val(res_val),
  .dly_wr(dly_wr), .dly_val(dly_val), .output_on(output_on), .err_rd(err_rd),
  .rd_valid(rd_valid), .rd_volt(rd_volt), .meas_cfg(meas_cfg), .filt_bypass(filt_bypass),
  .dly_ticks(dly_ticks), .dly_en(dly_en), .meas_allowed(meas_allowed),
  .err_code(err_code), .err_pending(err_pending));

// ===== verification/meas_source.sv
`timescale 1ns/10ps
module meas_source (
  // Clock
  input  wire logic                     clk_sys,
  // Sample request
  input  wire logic                     go,
  input  wire logic                     ovf,
  input  wire logic signed [31:0]       volt,
  input  wire logic signed [31:0]       curr,
  // Sample out
  output rel_offset_pkg::raw_meas_t     raw
);
  // Data lines flip between samples so stale values never look valid
  always_ff @(posedge clk_sys) begin
    raw <= '{go, go & ovf, go ? volt : ~raw.volt, go ? curr : ~raw.curr};
  end
endmodule : meas_source

// ===== verification/relative_offset_and_source_delay_bench.sv
`timescale 1ns/10ps
`define CHK(a, b) chk(64'(a), 64'(b))
module relative_offset_and_source_delay_bench;
  logic clk_sys, rst, trig_wait, ofs_wr, ofs_en_wr, ofs_en_val, cap_cmd, res_wr, dly_wr;
  logic dly_en_wr, dly_en_val, output_on, err_rd, go, ovf, rd_valid, filt_bypass, dly_en;
  logic meas_allowed, err_pending;
  rel_offset_pkg::func_t active_fn, ofs_wr_fn, ofs_en_fn, cap_fn, ofs_rd_fn;
  rel_offset_pkg::raw_meas_t raw;
  rel_offset_pkg::meas_cfg_t meas_cfg;
  logic signed [31:0] ofs_wr_val, dly_val, sv, sc, ofs_rd_val, rd_volt, rd_curr;
  logic [2:0] res_val, res_code;
  logic [23:0] dly_ticks;
  logic signed [15:0] err_code;
  logic [63:0] exp_q[$];
  logic [31:0] seed = 32'h0000ef64;
  int miscompares, checks, cycles, n;
  meas_source u_src (.clk_sys(clk_sys), .go(go), .ovf(ovf), .volt(sv), .curr(sc), .raw(raw));
  rel_offset_ctrl uut (
    .clk_sys(clk_sys), .rst(rst), .active_fn(active_fn), .raw(raw), .trig_wait(trig_wait),
    .ofs_wr(ofs_wr), .ofs_wr_fn(ofs_wr_fn), .ofs_wr_val(ofs_wr_val), .ofs_en_wr(ofs_en_wr),
    .ofs_en_fn(ofs_en_fn), .ofs_en_val(ofs_en_val), .cap_cmd(cap_cmd), .cap_fn(cap_fn),
    .res_wr(res_wr), .res_val(res_val), .dly_wr(dly_wr), .dly_val(dly_val),
    .dly_en_wr(dly_en_wr), .dly_en_val(dly_en_val), .output_on(output_on), .err_rd(err_rd),
    .ofs_rd_fn(ofs_rd_fn), .ofs_rd_val(ofs_rd_val), .rd_valid(rd_valid), .rd_volt(rd_volt),
    .rd_curr(rd_curr), .meas_cfg(meas_cfg), .filt_bypass(filt_bypass), .res_code(res_code),
    .dly_ticks(dly_ticks), .dly_en(dly_en), .meas_allowed(meas_allowed),
    .err_code(err_code), .err_pending(err_pending));
  function automatic logic signed [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return {{12{seed[19]}}, seed[19:0]};
  endfunction : xs
  task automatic chk(logic [63:0] a, logic [63:0] b);
    checks++;
    if (a !== b) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, a, b);
    end
  endtask : chk
  task automatic tick(int k = 1); repeat (k) @(posedge clk_sys); endtask : tick
  task automatic smp(logic signed [31:0] v, c, logic o, logic [63:0] e, logic q);
    sv <= v; sc <= c; ovf <= o; go <= 1'b1;
    if (q) exp_q.push_back(e);
    tick(); go <= 1'b0; tick(4);
  endtask : smp
  task automatic wofs(rel_offset_pkg::func_t f, logic signed [31:0] v);
    ofs_wr_fn <= f; ofs_wr_val <= v; ofs_wr <= 1'b1; tick(); ofs_wr <= 1'b0; tick(3);
  endtask : wofs
  task automatic eofs(rel_offset_pkg::func_t f);
    ofs_en_fn <= f; ofs_en_val <= 1'b1; ofs_en_wr <= 1'b1; tick(); ofs_en_wr <= 1'b0; tick();
  endtask : eofs
  task automatic cap(rel_offset_pkg::func_t f);
    cap_fn <= f; cap_cmd <= 1'b1; tick(); cap_cmd <= 1'b0; tick(2);
  endtask : cap
  task automatic rderr(); err_rd <= 1'b1; tick(); err_rd <= 1'b0; tick(2); endtask : rderr
  task automatic res(logic [2:0] c, e, logic [15:0] l, logic az, fe, logic [23:0] d);
    res_val <= c; res_wr <= 1'b1; tick(); res_wr <= 1'b0; tick(2);
    `CHK(meas_cfg, {l, az, rel_offset_pkg::FILT_COUNT, rel_offset_pkg::FILT_WINDOW, fe});
    `CHK({res_code, dly_ticks, dly_en}, {e, d, d != 0});
  endtask : res
  task automatic dly(logic signed [31:0] v);
    dly_val <= v; dly_wr <= 1'b1; tick(); dly_wr <= 1'b0; tick(2);
  endtask : dly
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      test_done();
    end
  end
  always @(negedge clk_sys) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) `CHK(rd_valid, 1'b0);
      else `CHK({rd_volt, rd_curr}, exp_q.pop_front());
    end
  end
  initial begin
    logic signed [31:0] v, c;
    {rst, trig_wait, ofs_wr, ofs_en_wr, ofs_en_val, cap_cmd, res_wr, dly_wr} = 8'hff;
    {dly_en_wr, dly_en_val, output_on, err_rd, go, ovf} = 6'h20;
    {trig_wait, ofs_wr, ofs_en_wr, ofs_en_val, cap_cmd, res_wr, dly_wr, dly_en_wr} = 8'h00;
    active_fn = rel_offset_pkg::FN_CURR;
    ofs_wr_fn = rel_offset_pkg::FN_CURR;
    ofs_en_fn = rel_offset_pkg::FN_CURR;
    cap_fn    = rel_offset_pkg::FN_CURR;
    ofs_rd_fn = rel_offset_pkg::FN_CURR;
    {ofs_wr_val, dly_val, sv, sc, res_val} = '0;
    tick(12);
    rst <= 1'b0;
    tick(2);
    `CHK({res_code, dly_ticks, dly_en}, {3'h6, 24'h000064, 1'b1});
    `CHK(meas_cfg, rel_offset_pkg::CFG_RESET);
    `CHK(ofs_rd_val, 0);
    v = xs(); c = xs();
    smp(v, c, 1'b0, {v, c}, 1'b1);
    wofs(rel_offset_pkg::FN_CURR, 1000);
    wofs(rel_offset_pkg::FN_CURR, 6100001);
    `CHK(ofs_rd_val, 1000);
    eofs(rel_offset_pkg::FN_CURR);
    smp(v, c, 1'b0, {v, c - 32'sd1000}, 1'b1);
    active_fn <= rel_offset_pkg::FN_CONC;
    wofs(rel_offset_pkg::FN_CONC, -500);
    eofs(rel_offset_pkg::FN_CONC);
    smp(v, c, 1'b0, {v, c + 32'sd500}, 1'b1);
    active_fn <= rel_offset_pkg::FN_VOLT;
    wofs(rel_offset_pkg::FN_VOLT, 20000000);
    wofs(rel_offset_pkg::FN_VOLT, -20000001);
    eofs(rel_offset_pkg::FN_VOLT);
    smp(v, c, 1'b0, {v - 32'sd20000000, c}, 1'b1);
    $display("offset tests done");
    active_fn <= rel_offset_pkg::FN_CURR;
    cap(rel_offset_pkg::FN_CURR);
    `CHK(filt_bypass, 1'b1);
    smp(v, c, 1'b0, 0, 1'b0);
    `CHK(ofs_rd_val, c);
    cap(rel_offset_pkg::FN_CURR);
    smp(v, c + 32'sd7, 1'b1, 0, 1'b0);
    `CHK({ofs_rd_val, err_code, err_pending}, {c, rel_offset_pkg::ERR_EXEC, 1'b1});
    rderr();
    `CHK(err_pending, 1'b0);
    cap(rel_offset_pkg::FN_VOLT);
    `CHK(err_pending, 1'b1);
    rderr();
    trig_wait <= 1'b1;
    cap(rel_offset_pkg::FN_CURR);
    `CHK({err_code, err_pending, filt_bypass}, {rel_offset_pkg::ERR_EXEC, 2'b10});
    trig_wait <= 1'b0;
    $display("capture tests done");
    res(3'h4, 3'h4, rel_offset_pkg::LCI_RES4, 1'b0, 1'b1, 24'h000000);
    res(3'h5, 3'h5, rel_offset_pkg::LCI_RES5, 1'b0, 1'b0, 24'h000064);
    res(3'h7, 3'h5, rel_offset_pkg::LCI_RES5, 1'b0, 1'b0, 24'h000064);
    res(3'h6, 3'h6, rel_offset_pkg::LCI_RES6, 1'b1, 1'b0, 24'h000064);
    $display("resolution tests done");
    dly(-1);
    `CHK({err_code, dly_ticks}, {rel_offset_pkg::ERR_RANGE, 24'h000064});
    rderr();
    dly(9900001);
    `CHK({err_code, err_pending, dly_ticks}, {rel_offset_pkg::ERR_RANGE, 1'b1, 24'h000064});
    dly(2);
    output_on <= 1'b1;
    n = 0;
    while (meas_allowed !== 1'b1 && n < 3000) begin
      tick();
      n++;
    end
    `CHK(n >= 2000 && n <= 2010, 1'b1);
    output_on <= 1'b0;
    dly_en_val <= 1'b0; dly_en_wr <= 1'b1; tick(); dly_en_wr <= 1'b0; tick(3);
    `CHK(meas_allowed, 1'b0);
    output_on <= 1'b1;
    tick(4);
    `CHK({dly_en, meas_allowed}, 2'b01);
    $display("delay tests done");
    test_done();
  end
endmodule : relative_offset_and_source_delay_bench
